// [design/dsd_data_space.sv]
// What this block does
// - Data 40h..7Fh read program memory bytes, not RAM.
// - Program address is window page above low six data-address bits.
// - Window moves in 64-byte steps over program bytes 0000h..1FFFh.
// - Window page at C9h is write only; reads and bit ops unsupported.
// - Only window page bits 6..0 exist; bit 7 dropped.
// - Window page has no reset value; software writes it first.
// - Bank select 08h maps page one, 10h page two, 00h none.
// - Selected bank is reached at data addresses 00h..3Fh.
// - Bank select at CBh is write only, no bit operations.
// - Bank select has no reset value; software programs it first.
// - Interrupts and calls leave bank select untouched.
// - Sixty direct RAM bytes plus core registers at fixed addresses.
// - Two extra banked pages of 64 bytes each.
// - At reset the two option bytes are read and applied.
// - Option bytes reachable only in programming mode, no address.
`timescale 1ns/1ps
`default_nettype none
module dsd_data_space (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Core data-space bus
    input  wire logic [7:0]  core_addr_i,
    input  wire logic        core_rd_i,
    input  wire logic        core_wr_i,
    input  wire logic [7:0]  core_wdata_i,
    output var  logic [7:0]  core_rdata_o,
    output var  logic        core_rvalid_o,
    // Program memory read port
    output var  logic [12:0] prog_addr_o,
    output var  logic        prog_rd_o,
    input  wire logic [7:0]  prog_rdata_i,
    // Option byte store
    input  wire logic        prog_mode_i,
    input  wire logic        opt_wr_i,
    input  wire logic [15:0] opt_wdata_i,
    output var  logic [15:0] option_bytes_o,
    output var  logic        options_valid_o,
    // Peripheral slot
    output var  logic        periph_sel_o
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic in_bank;
    logic in_window;
    logic in_direct;
    logic in_core_reg;
    logic in_periph;
    assign in_bank     = core_addr_i <= dsd_pkg::BANK_AREA_LAST;
    assign in_window   = core_addr_i >= dsd_pkg::ROM_WINDOW_FIRST &&
                         core_addr_i <= dsd_pkg::ROM_WINDOW_LAST;
    assign in_direct   = core_addr_i >= dsd_pkg::DIRECT_RAM_FIRST &&
                         core_addr_i <= dsd_pkg::DIRECT_RAM_LAST;
    assign in_core_reg = core_addr_i == dsd_pkg::X_REG_ADDR ||
                         core_addr_i == dsd_pkg::Y_REG_ADDR ||
                         core_addr_i == dsd_pkg::V_REG_ADDR ||
                         core_addr_i == dsd_pkg::W_REG_ADDR ||
                         core_addr_i == dsd_pkg::ACCUMULATOR_ADDR;
    assign in_periph   = core_addr_i >= dsd_pkg::PERIPH_FIRST && !in_core_reg &&
                         core_addr_i != dsd_pkg::ROM_WINDOW_PAGE_ADDR &&
                         core_addr_i != dsd_pkg::RAM_BANK_SELECT_ADDR;

    // ----------------------------------------------------------------
    // Write-only page registers
    // ----------------------------------------------------------------
    // No reset: contents undefined until software writes them
    logic [6:0] window_upper_address_bits;
    logic [7:0] ram_bank_select;

    always_ff @(posedge clk_sys_i) begin
        if (core_wr_i && core_addr_i == dsd_pkg::ROM_WINDOW_PAGE_ADDR) begin
            window_upper_address_bits <= core_wdata_i[6:0];
        end
    end

    // Only core writes touch it; no interrupt or call path exists
    always_ff @(posedge clk_sys_i) begin
        if (core_wr_i && core_addr_i == dsd_pkg::RAM_BANK_SELECT_ADDR) begin
            ram_bank_select <= core_wdata_i;
        end
    end

    logic select_page_one;
    logic select_page_two;
    assign select_page_one = ram_bank_select == dsd_pkg::BANK_PAGE_ONE;
    assign select_page_two = ram_bank_select == dsd_pkg::BANK_PAGE_TWO;

    // ----------------------------------------------------------------
    // RAM: bank 0, two extra pages, direct RAM, core registers
    // ----------------------------------------------------------------
    // One 128-byte array holds both extra pages; reserved codes use bank 0
    logic       xbank_we;
    logic [6:0] xbank_addr;
    logic [7:0] xbank_rdata;
    assign xbank_we   = core_wr_i && in_bank && (select_page_one || select_page_two);
    assign xbank_addr = {select_page_two, core_addr_i[5:0]};

    dsd_ram #(.AW(dsd_pkg::BANK_ADDR_BITS)) u_xbank (
        .clk_i   (clk_sys_i),
        .we_i    (xbank_we),
        .addr_i  (xbank_addr),
        .wdata_i (core_wdata_i),
        .rdata_o (xbank_rdata)
    );

    // Bank 0 plus 80h..BFh and the accumulator as a flat byte array
    logic [7:0] base_ram [0:255];
    logic [7:0] base_rdata;
    logic       base_we;
    assign base_we = core_wr_i && ((in_bank && !(select_page_one || select_page_two)) ||
                                   in_direct || in_core_reg);

    always_ff @(posedge clk_sys_i) begin
        if (base_we) begin
            base_ram[core_addr_i] <= core_wdata_i;
        end
        base_rdata <= base_ram[core_addr_i];
    end

    // ----------------------------------------------------------------
    // Window read path
    // ----------------------------------------------------------------
    // Address to program memory: page on top, offset below
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_addr_o <= 13'h0000;
            prog_rd_o   <= 1'b0;
        end else begin
            prog_rd_o <= core_rd_i && in_window;
            if (core_rd_i && in_window) begin
                prog_addr_o <= {window_upper_address_bits, core_addr_i[5:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data return, three-cycle latency
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_NONE = 3'b001,
        SRC_XB   = 3'b010,
        SRC_BASE = 3'b100
    } dsd_src_e;

    dsd_src_e   src_q;
    logic       window_q;
    logic       rd_q;
    logic       rd_q2;
    logic [7:0] ram_hold;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_q    <= SRC_NONE;
            window_q <= 1'b0;
            rd_q     <= 1'b0;
        end else begin
            rd_q     <= core_rd_i;
            window_q <= core_rd_i && in_window;
            if (core_rd_i && in_bank && (select_page_one || select_page_two)) begin
                src_q <= SRC_XB;
            end else if (core_rd_i && (in_bank || in_direct || in_core_reg)) begin
                src_q <= SRC_BASE;
            end else begin
                src_q <= SRC_NONE;
            end
        end
    end

    logic win_q2;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q2    <= 1'b0;
            win_q2   <= 1'b0;
            ram_hold <= 8'h00;
        end else begin
            rd_q2  <= rd_q;
            win_q2 <= window_q;
            case (src_q)
                SRC_XB:   ram_hold <= xbank_rdata;
                SRC_BASE: ram_hold <= base_rdata;
                SRC_NONE: ram_hold <= 8'h00;
                default:  ram_hold <= 8'h00;
            endcase
        end
    end

    // Write-only and unmapped locations read as zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_rdata_o  <= 8'h00;
            core_rvalid_o <= 1'b0;
        end else begin
            core_rvalid_o <= rd_q2;
            core_rdata_o  <= win_q2 ? prog_rdata_i : ram_hold;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_sel_o <= 1'b0;
        end else begin
            periph_sel_o <= (core_rd_i || core_wr_i) && in_periph;
        end
    end

    // ----------------------------------------------------------------
    // Option bytes
    // ----------------------------------------------------------------
    // Store lives outside core map; loaded into the live copy after reset
    // Non-volatile: blank value at power-up, survives every reset
    logic [15:0]             opt_store = dsd_pkg::OPTION_BYTES_RESET;
    dsd_pkg::dsd_opt_state_e opt_state;

    always_ff @(posedge clk_sys_i) begin
        if (prog_mode_i && opt_wr_i) begin
            opt_store <= opt_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_state       <= dsd_pkg::DSD_OPT_LOW;
            option_bytes_o  <= 16'h0000;
            options_valid_o <= 1'b0;
        end else begin
            case (opt_state)
                dsd_pkg::DSD_OPT_LOW: begin
                    option_bytes_o[7:0] <= opt_store[7:0];
                    opt_state           <= dsd_pkg::DSD_OPT_HIGH;
                end
                dsd_pkg::DSD_OPT_HIGH: begin
                    option_bytes_o[15:8] <= opt_store[15:8];
                    opt_state            <= dsd_pkg::DSD_OPT_DONE;
                end
                dsd_pkg::DSD_OPT_DONE: begin
                    options_valid_o <= 1'b1;
                    opt_state       <= dsd_pkg::DSD_OPT_IDLE;
                end
                dsd_pkg::DSD_OPT_IDLE: begin
                    opt_state <= dsd_pkg::DSD_OPT_IDLE;
                end
                default: begin
                    opt_state <= dsd_pkg::DSD_OPT_LOW;
                end
            endcase
        end
    end
endmodule : dsd_data_space
`default_nettype wire

// [design/dsd_pkg.sv]
package dsd_pkg;

    // ----------------------------------------------------------------
    // Data-space map
    // ----------------------------------------------------------------
    localparam logic [7:0] BANK_AREA_LAST       = 8'h3f;
    localparam logic [7:0] ROM_WINDOW_FIRST     = 8'h40;
    localparam logic [7:0] ROM_WINDOW_LAST      = 8'h7f;
    localparam logic [7:0] X_REG_ADDR           = 8'h80;
    localparam logic [7:0] Y_REG_ADDR           = 8'h81;
    localparam logic [7:0] V_REG_ADDR           = 8'h82;
    localparam logic [7:0] W_REG_ADDR           = 8'h83;
    localparam logic [7:0] DIRECT_RAM_FIRST     = 8'h84;
    localparam logic [7:0] DIRECT_RAM_LAST      = 8'hbf;
    localparam logic [7:0] PERIPH_FIRST         = 8'hc0;
    localparam logic [7:0] ROM_WINDOW_PAGE_ADDR = 8'hc9;
    localparam logic [7:0] RAM_BANK_SELECT_ADDR = 8'hcb;
    localparam logic [7:0] ACCUMULATOR_ADDR     = 8'hff;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    localparam int WINDOW_OFFSET_BITS = 6;
    localparam int WINDOW_PAGE_BITS   = 7;
    localparam int PROG_ADDR_BITS     = 13;
    localparam int SELECT_PAGE_ONE_BIT = 3;
    localparam int SELECT_PAGE_TWO_BIT = 4;
    localparam logic [7:0] BANK_NONE     = 8'h00;
    localparam logic [7:0] BANK_PAGE_ONE = 8'h08;
    localparam logic [7:0] BANK_PAGE_TWO = 8'h10;

    // ----------------------------------------------------------------
    // Memory sizes
    // ----------------------------------------------------------------
    localparam int BANK_ADDR_BITS = 7;
    localparam int DIRECT_RAM_BYTES = 60;
    localparam logic [15:0] OPTION_BYTES_RESET = 16'h0010;

    typedef enum logic [3:0] {
        DSD_OPT_LOW  = 4'b0001,
        DSD_OPT_HIGH = 4'b0010,
        DSD_OPT_DONE = 4'b0100,
        DSD_OPT_IDLE = 4'b1000
    } dsd_opt_state_e;

endpackage : dsd_pkg

// [design/dsd_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module dsd_ram #(
    parameter int AW = 7
) (
    // Clock
    input  wire logic          clk_i,
    // Access
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    output var  logic [7:0]    rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : dsd_ram
`default_nettype wire

// [bench/dsd_data_space_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dsd_data_space_asserts (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // Core bus
    input wire logic [7:0]  core_addr_i,
    input wire logic        core_rd_i,
    input wire logic        core_wr_i,
    input wire logic [7:0]  core_wdata_i,
    input wire logic [7:0]  core_rdata_o,
    input wire logic        core_rvalid_o,
    // Program memory and options
    input wire logic [12:0] prog_addr_o,
    input wire logic        prog_rd_o,
    input wire logic [7:0]  prog_rdata_i,
    input wire logic [15:0] option_bytes_o,
    input wire logic        options_valid_o,
    input wire logic        periph_sel_o
);
    // ----
    // Helper logic
    // ----
    // Page copy has no reset, like the real register
    logic [6:0] page;
    logic       win_rd;
    logic [5:0] off;
    logic       periph;
    always_ff @(posedge clk_sys_i) begin
        if (core_wr_i && core_addr_i == 8'hc9) begin
            page <= core_wdata_i[6:0];
        end
    end
    assign win_rd = core_rd_i && core_addr_i[7:6] == 2'b01;
    assign off    = core_addr_i[5:0];
    assign periph = core_addr_i >= 8'hc0 && core_addr_i != 8'hc9
                    && core_addr_i != 8'hcb && core_addr_i != 8'hff;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_opt_load;
        !options_valid_o [*3] ##1 options_valid_o;
    endsequence
    // ----
    // Properties
    // ----
    a_window_strobe: assert property (win_rd |=> prog_rd_o)
        else $error("window read gave no strobe");
    a_strobe_cause: assert property (prog_rd_o |-> $past(win_rd))
        else $error("strobe without window read");
    a_window_addr: assert property (win_rd |=> prog_addr_o == {page, $past(off)})
        else $error("window address wrong");
    a_window_data: assert property (win_rd |-> ##3 core_rdata_o == $past(prog_rdata_i))
        else $error("window data wrong");
    a_read_answer: assert property (core_rd_i |-> ##3 core_rvalid_o)
        else $error("read answer late");
    a_answer_cause: assert property (core_rvalid_o |-> $past(core_rd_i, 3))
        else $error("answer without read");
    a_wo_readback: assert property (core_rd_i && (core_addr_i == 8'hc9
        || core_addr_i == 8'hcb) |-> ##3 core_rdata_o == 8'h00)
        else $error("write-only register read back");
    a_periph_sel: assert property ((core_rd_i || core_wr_i) && periph |=> periph_sel_o)
        else $error("peripheral select missing");
    a_option_load: assert property ($rose(rst_n_i) |-> s_opt_load)
        else $error("options not loaded in time");
    a_option_hold: assert property (options_valid_o |=> $stable(option_bytes_o))
        else $error("options changed after load");
endmodule : dsd_data_space_asserts

bind dsd_data_space dsd_data_space_asserts u_chk (.*);
`default_nettype wire

// [bench/dsd_prog_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsd_prog_mem_model (
    // Read port
    input  wire logic        clk_i,
    input  wire logic [12:0] prog_addr_i,
    input  wire logic        prog_rd_i,
    output logic [7:0]       prog_rdata_o
);
    // ----
    // Byte store
    // ----
    // Data is valid one cycle only; otherwise it toggles so stale use shows
    initial prog_rdata_o = 8'h00;
    always @(posedge clk_i) begin
        if (prog_rd_i) begin
            prog_rdata_o <= prog_addr_i[7:0] ^ {prog_addr_i[12:8], 3'h5};
        end else begin
            prog_rdata_o <= ~prog_rdata_o;
        end
    end
endmodule : dsd_prog_mem_model
`default_nettype wire

// [bench/dsd_data_space_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dsd_data_space_tb;
    // ----
    // Wiring
    // ----
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  core_addr_i = 8'h00;
    logic        core_rd_i = 1'b0;
    logic        core_wr_i = 1'b0;
    logic [7:0]  core_wdata_i = 8'h00;
    logic        prog_mode_i = 1'b0;
    logic        opt_wr_i = 1'b0;
    logic [15:0] opt_wdata_i = 16'h0000;
    logic [7:0]  core_rdata_o, prog_rdata_i;
    logic        core_rvalid_o, prog_rd_o, options_valid_o, periph_sel_o;
    logic [12:0] prog_addr_o;
    logic [15:0] option_bytes_o;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [7:0]  bsel [3] = '{8'h00, 8'h08, 8'h10};
    logic [7:0]  radr [5] = '{8'h80, 8'h83, 8'h84, 8'hbf, 8'hff};
    logic [7:0]  pgs [4] = '{8'h00, 8'h7f, 8'hff, 8'h2a};

    dsd_data_space dut (.*);
    dsd_prog_mem_model u_prog (.clk_i(clk_sys_i), .prog_addr_i(prog_addr_o),
                               .prog_rd_i(prog_rd_o), .prog_rdata_o(prog_rdata_i));
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ----
    // Tasks
    // ----
    function automatic logic [7:0] pm(input logic [12:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction : pm
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic do_reset;
        rst_n_i = 1'b0;
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        {core_addr_i, core_wdata_i, core_wr_i} = {a, d, 1'b1};
        @(negedge clk_sys_i);
        core_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int n;
        @(negedge clk_sys_i);
        {core_addr_i, core_rd_i} = {a, 1'b1};
        @(negedge clk_sys_i);
        core_rd_i = 1'b0;
        n = 0;
        while (core_rvalid_o !== 1'b1 && n < 8) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 8) begin
            fail_count++;
            print_verdict();
        end
        chk({8'h00, core_rdata_o}, {8'h00, exp});
    endtask : rd
    task automatic opt(input logic m, input logic [15:0] d);
        @(negedge clk_sys_i);
        {prog_mode_i, opt_wdata_i, opt_wr_i} = {m, d, 1'b1};
        @(negedge clk_sys_i);
        {prog_mode_i, opt_wr_i} = 2'b00;
    endtask : opt
    // ----
    // Tests
    // ----
    initial begin
        do_reset();
        chk({15'h0, options_valid_o}, 16'h0001);
        chk(option_bytes_o, 16'h0010);
        $display("test option reset done");
        foreach (pgs[i]) begin
            wr(8'h84, pgs[i]);
            wr(8'hc9, pgs[i]);
            rd(8'h40, pm({pgs[i][6:0], 6'h00}));
            rd(8'h7f, pm({pgs[i][6:0], 6'h3f}));
            chk({3'h0, prog_addr_o}, {3'h0, pgs[i][6:0], 6'h3f});
        end
        wr(8'h45, 8'ha5);
        rd(8'h45, pm({7'h2a, 6'h05}));
        rd(8'hc9, 8'h00);
        rd(8'hcb, 8'h00);
        rd(8'hd0, 8'h00);
        $display("test window done");
        foreach (bsel[i]) begin
            wr(8'hcb, bsel[i]);
            wr(8'h00, 8'h11 + 8'(i * 16));
            wr(8'h3f, 8'h1e + 8'(i * 16));
        end
        foreach (bsel[i]) begin
            wr(8'hcb, bsel[i]);
            rd(8'h00, 8'h11 + 8'(i * 16));
            rd(8'h3f, 8'h1e + 8'(i * 16));
        end
        foreach (radr[i]) wr(radr[i], radr[i] ^ 8'h3c);
        foreach (radr[i]) rd(radr[i], radr[i] ^ 8'h3c);
        $display("test ram done");
        opt(1'b1, 16'h3c5a);
        opt(1'b0, 16'hffff);
        chk(option_bytes_o, 16'h0010);
        do_reset();
        chk(option_bytes_o, 16'h3c5a);
        $display("test option store done");
        print_verdict();
    end
endmodule : dsd_data_space_tb
`default_nettype wire
